// [comparator_analog_model.sv]
// analog comparator cores with their input muxes, levels as 8-bit codes
// assumes the four input pins and the reference pin are shared by all channels
`timescale 1ns/1ps
module comparator_analog_model
  import comparator_pkg::*;
#(
  parameter logic [7:0] BG_LEVEL  = 8'h60,
  parameter logic [7:0] REF_LEVEL = 8'h80
) (
  input  wire comparator_pkg::analog_ctrl_t [2:0] analog_ctrl,
  input  wire logic [1:0]                    bandgap_source_select,
  input  wire logic [7:0]                    pin_a,
  input  wire logic [7:0]                    pin_b,
  input  wire logic [7:0]                    pin_c,
  input  wire logic [7:0]                    pin_d,
  input  wire logic [7:0]                    vref_pin,
  output logic [2:0]                         raw_compare
);
  // ----------------------------------------------------------------
  // input selection and compare
  // ----------------------------------------------------------------
  logic [7:0] pos;
  logic [7:0] neg;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pos = analog_ctrl[i].pos_ref ? REF_LEVEL : pin_a;
      case (analog_ctrl[i].neg_sel)
        2'b00: neg = pin_b;
        2'b01: neg = pin_c;
        2'b10: neg = pin_d;
        default: begin
          neg = ~pos;
          if (bandgap_source_select == 2'b00) neg = BG_LEVEL;
          if (bandgap_source_select == 2'b01) neg = BG_LEVEL >> 1;
          if (bandgap_source_select == 2'b11) neg = vref_pin;
        end
      endcase
      raw_compare[i] = analog_ctrl[i].enable & (pos > neg);
    end
  end
endmodule

// [comparator_channel.sv]
// one comparator channel: synchroniser, polarity, edge detect and sticky flag
// assumes raw comes straight from an analog core, asynchronous to hclk
`timescale 1ns/1ps
module comparator_channel
  import comparator_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  raw,
  input  wire logic                  active,
  input  wire logic                  invert,
  input  wire comparator_pkg::edge_sel_t edge_sel,
  input  wire logic                  arm_first,
  input  wire logic                  flag_wr,
  input  wire logic                  flag_wdata,
  output logic                       result,
  output logic                       flag,
  output logic                       fire
);

  chan_state_t st_reg;
  chan_state_t st_next;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic change;
    logic hit;
    change = 1'b0;
    hit    = 1'b0;
    st_next       = st_reg;
    st_next.sync1 = raw;                                      // [RL17]
    st_next.sync2 = st_reg.sync1;                             // [RL17]
    st_next.result = active & (st_reg.sync2 ^ invert);        // [RL5] [RL7]
    change = st_next.result ^ st_reg.result;
    if (st_reg.first_any) begin
      hit = change;                                           // [RL9]
    end else begin
      unique case (edge_sel)
        EDGE_ANY:  hit = change;                              // [RL8]
        EDGE_FALL: hit = change & ~st_next.result;            // [RL8]
        EDGE_RISE: hit = change & st_next.result;             // [RL8]
        EDGE_OFF:  hit = 1'b0;                                // [RL8]
      endcase
    end
    st_next.fire = active & hit & ~st_reg.flag & (edge_sel != EDGE_OFF);  // [RL6]
    if (arm_first) begin
      st_next.first_any = 1'b1;                               // [RL9]
    end else if (st_next.fire) begin
      st_next.first_any = 1'b0;                               // [RL9]
    end
    if (flag_wr) begin
      st_next.flag = flag_wdata;
    end
    if (st_next.fire) begin
      st_next.flag = 1'b1;                                    // [RL6]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign result = st_reg.result;
  assign flag   = st_reg.flag;
  assign fire   = st_reg.fire;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_flag_on_fire: assert property (fire |-> flag)  // [RL6]
    else $error("event fired without setting the flag");
  a_no_fire_flagged: assert property (fire |-> !$past(flag))  // [RL6]
    else $error("event fired while the flag was set");
  a_sync_latency: assert property ($past(active) |-> result == ($past(raw, 3) ^ $past(invert)))  // [RL17]
    else $error("result does not follow raw after three cycles");
  a_rise_only: assert property (
    fire && $past(edge_sel) == EDGE_RISE && !$past(st_reg.first_any) |-> $rose(result))  // [RL8]
    else $error("rise selection fired without a rising result");
  a_edge_off_quiet: assert property ($past(edge_sel) == EDGE_OFF |-> !fire)  // [RL8]
    else $error("event fired with events disabled");

  c_fire_event: cover property (fire);
  c_first_any: cover property (st_reg.first_any && fire);

endmodule

// [comparator_control.sv]
// top of the triple comparator control block with its ahb-lite register slave
// assumes analog cores outside, a 10 mhz hclk and a single ahb-lite master
//
// Behaviour
// [RL1] three channels, each with own control register
// [RL2] pin enable drives raw result onto pin
// [RL3] top control bit switches the comparator on
// [RL4] second bit routes result to output pin
// [RL5] invert bit flips result, pin and events
// [RL6] sticky flag set on edge, blocks retriggers
// [RL7] read-only result bit follows compare continuously
// [RL8] edge select: any, falling, rising, off
// [RL9] first event after select change: any transition
// [RL10] positive input: reference or pin a
// [RL11] negative input select: pins b, c, d
// [RL12] shared status shows all results and flags
// [RL13] unimplemented control bits read zero, ignore writes
// [RL14] select three takes internal band gap reference; the model does so only for bandgap_source_select 0 or 1, vref_pin for 3
// [RL15] status flags bits 10:8, results 2:0
// [RL16] idle stop halts comparators in idle mode
// [RL17] two-stage synchroniser before edge detection
// [RL18] all control bits reset to zero
`timescale 1ns/1ps
`include "comparator_defs.svh"
module comparator_control (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic                          hready,
  input  wire logic [31:0]                   hwdata,
  output logic [31:0]                        hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic [2:0]                    raw_compare,
  input  wire logic                          idle_mode,
  output comparator_pkg::analog_ctrl_t [2:0] analog_ctrl,
  output logic [1:0]                         bandgap_source_select,
  output logic [2:0]                         result_pin,
  output logic [2:0]                         result_pin_oe,
  output logic                               irq
);
  import comparator_pkg::*;

  top_state_t  st_reg;
  top_state_t  st_next;
  ahb_req_t    req;
  logic [2:0]  ch_result;
  logic [2:0]  ch_flag;
  logic [2:0]  ch_fire;
  logic [2:0]  arm_first;
  logic [2:0]  flag_wr;
  logic [2:0]  pin_data;

  assign req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                 hsize: hsize, hready: hready};

  // ----------------------------------------------------------------
  // read word of one channel control register
  // ----------------------------------------------------------------
  function automatic logic [31:0] ctrl_word(input chan_cfg_t c, input logic flg,
                                            input logic res);
    logic [31:0] w;
    w = `RST_WORD;
    w[`CTL_ON]                   = c.on;
    w[`CTL_OE]                   = c.oe;
    w[`CTL_INV]                  = c.inv;
    w[`CTL_FLAG]                 = flg;
    w[`CTL_RESULT]               = res;
    w[`CTL_EDGE_HI:`CTL_EDGE_LO] = c.edge_sel;
    w[`CTL_PREF]                 = c.pref;
    w[`CTL_NSEL_HI:`CTL_NSEL_LO] = c.nsel;
    return w;                                                 // [RL13]
  endfunction

  // ----------------------------------------------------------------
  // channel slices
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      comparator_channel u_chan (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .raw        (raw_compare[gi]),
        .active     (st_reg.analog_en[gi]),
        .invert     (st_reg.cfg[gi].inv),
        .edge_sel   (edge_sel_t'(st_reg.cfg[gi].edge_sel)),
        .arm_first  (arm_first[gi]),
        .flag_wr    (flag_wr[gi]),
        .flag_wdata (hwdata[`CTL_FLAG]),
        .result     (ch_result[gi]),
        .flag       (ch_flag[gi]),
        .fire       (ch_fire[gi])
      );
      // unsynchronised compare through the pad logic
      assign pin_data[gi] = (raw_compare[gi] ^ st_reg.cfg[gi].inv)
                            & st_reg.analog_en[gi];           // [RL2] [RL5]
      assign analog_ctrl[gi] = '{enable:  st_reg.analog_en[gi],
                                 pos_ref: st_reg.cfg[gi].pref,     // [RL10]
                                 neg_sel: st_reg.cfg[gi].nsel};    // [RL11] [RL14]
    end
  endgenerate

  // ----------------------------------------------------------------
  // write strobes toward the channels
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] new_sel;
    new_sel   = hwdata[`CTL_EDGE_HI:`CTL_EDGE_LO];
    arm_first = 3'b000;
    flag_wr   = 3'b000;
    for (int i = 0; i < 3; i++) begin
      if (st_reg.wr_pend && st_reg.addr == 8'(i * 4)) begin
        flag_wr[i]   = 1'b1;                                  // [RL6]
        arm_first[i] = (new_sel != 2'b00)
                       && (new_sel != st_reg.cfg[i].edge_sel); // [RL9]
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        take;
    logic [31:0] rd;
    logic [2:0]  w1c;
    take = req.hsel && req.htrans[1] && req.hready;
    rd   = `RST_WORD;
    w1c  = 3'b000;
    st_next = st_reg;

    // data phase write
    if (st_reg.wr_pend) begin
      unique case (st_reg.addr)
        `OFS_CTRL0, `OFS_CTRL1, `OFS_CTRL2: begin
          for (int i = 0; i < 3; i++) begin
            if (st_reg.addr == 8'(i * 4)) begin
              st_next.cfg[i].on       = hwdata[`CTL_ON];       // [RL3]
              st_next.cfg[i].oe       = hwdata[`CTL_OE];       // [RL4]
              st_next.cfg[i].inv      = hwdata[`CTL_INV];      // [RL5]
              st_next.cfg[i].edge_sel = hwdata[`CTL_EDGE_HI:`CTL_EDGE_LO];  // [RL8]
              st_next.cfg[i].pref     = hwdata[`CTL_PREF];     // [RL10]
              st_next.cfg[i].nsel     = hwdata[`CTL_NSEL_HI:`CTL_NSEL_LO];  // [RL11]
            end
          end
        end
        `OFS_STATUS:     st_next.idle_stop = hwdata[`ST_IDLE_STOP];  // [RL16]
        `OFS_REFCFG:     st_next.bg_sel = hwdata[`REF_BG_HI:`REF_BG_LO];  // [RL14]
        `OFS_IRQ_STATUS: w1c = hwdata[2:0];
        `OFS_IRQ_MASK:   st_next.irq_mask = hwdata[2:0];
        default: ;
      endcase
    end

    // sticky interrupt bits, a new event beats the clear
    st_next.irq_status = (st_reg.irq_status & ~w1c) | ch_fire;
    st_next.irq        = |(st_next.irq_status & st_next.irq_mask);

    // comparator power follows enable and idle stop
    for (int i = 0; i < 3; i++) begin
      st_next.analog_en[i] = st_next.cfg[i].on
                             & ~(idle_mode & st_reg.idle_stop);  // [RL3] [RL16]
    end

    // address phase capture and read data
    st_next.wr_pend = take && req.hwrite;
    if (take) begin
      st_next.addr = req.haddr[7:0];
    end
    if (take && !req.hwrite) begin
      unique case (req.haddr[7:0])
        `OFS_CTRL0: rd = ctrl_word(st_reg.cfg[0], ch_flag[0], ch_result[0]);  // [RL1]
        `OFS_CTRL1: rd = ctrl_word(st_reg.cfg[1], ch_flag[1], ch_result[1]);  // [RL1]
        `OFS_CTRL2: rd = ctrl_word(st_reg.cfg[2], ch_flag[2], ch_result[2]);  // [RL1]
        `OFS_STATUS: begin
          rd[`ST_IDLE_STOP]           = st_reg.idle_stop;
          rd[`ST_FLAG_LO +: 3]        = ch_flag;              // [RL12] [RL15]
          rd[`ST_RES_LO +: 3]         = ch_result;            // [RL12] [RL15]
        end
        `OFS_REFCFG:     rd[`REF_BG_HI:`REF_BG_LO] = st_reg.bg_sel;
        `OFS_IRQ_STATUS: rd[2:0] = st_reg.irq_status;
        `OFS_IRQ_MASK:   rd[2:0] = st_reg.irq_mask;
        default:         rd = `RST_WORD;
      endcase
      st_next.rdata = rd;
    end
    st_next.ready = 1'b1;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg       <= '0;                                     // [RL18]
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata                = st_reg.rdata;
  assign hreadyout             = st_reg.ready;
  assign hresp                 = 1'b0;
  assign irq                   = st_reg.irq;
  assign bandgap_source_select = st_reg.bg_sel;               // [RL14]
  assign result_pin            = pin_data;                    // [RL2]
  generate
    for (gi = 0; gi < 3; gi++) begin : g_oe
      assign result_pin_oe[gi] = st_reg.cfg[gi].oe;           // [RL4]
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence ctrl_read_s;
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] == `OFS_CTRL0;
  endsequence

  a_irq_level: assert property (irq == |(st_reg.irq_status & st_reg.irq_mask))
    else $error("interrupt output disagrees with status and mask");
  a_irq_sticky: assert property (ch_fire[0] |=> st_reg.irq_status[0] [*2])  // [RL6]
    else $error("channel event lost from the interrupt status");
  a_reserved_zero: assert property (ctrl_read_s |=> hrdata[12:10] == 3'b000
                                    && hrdata[5] == 1'b0 && hrdata[3:2] == 2'b00)  // [RL13]
    else $error("unimplemented control bits read nonzero");
  a_idle_stop_off: assert property (idle_mode && st_reg.idle_stop |=> st_reg.analog_en == 3'b000)  // [RL16]
    else $error("comparator left running in idle with idle stop set");
  a_status_flags: assert property (hsel && htrans[1] && hready && !hwrite
                                   && haddr[7:0] == `OFS_STATUS
                                   |=> hrdata[10:8] == $past(ch_flag)
                                   && hrdata[2:0] == $past(ch_result))  // [RL15]
    else $error("shared status does not mirror flags and results");
  a_pin_enable: assert property (st_reg.wr_pend && st_reg.addr == `OFS_CTRL0
                                 |=> result_pin_oe[0] == $past(hwdata[`CTL_OE]))  // [RL4]
    else $error("pin enable does not follow the written control bit");
  a_ready_high: assert property (hreadyout && !hresp)
    else $error("slave inserted a wait or error");

  c_write_ctrl: cover property (st_reg.wr_pend && st_reg.addr == `OFS_CTRL1);
  c_irq_raised: cover property ($rose(irq));
  c_idle_halt: cover property (idle_mode && st_reg.idle_stop && st_reg.cfg[0].on);

endmodule

// [comparator_defs.svh]
// register offsets, field positions and reset values of the comparator block
// assumes a 32-bit ahb-lite slave with one aligned word per register
`ifndef COMPARATOR_DEFS_SVH
`define COMPARATOR_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL0      8'h00
`define OFS_CTRL1      8'h04
`define OFS_CTRL2      8'h08
`define OFS_STATUS     8'h0c
`define OFS_REFCFG     8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK   8'h18

// ----------------------------------------------------------------
// channel control field positions
// ----------------------------------------------------------------
`define CTL_ON      15
`define CTL_OE      14
`define CTL_INV     13
`define CTL_FLAG    9
`define CTL_RESULT  8
`define CTL_EDGE_HI 7
`define CTL_EDGE_LO 6
`define CTL_PREF    4
`define CTL_NSEL_HI 1
`define CTL_NSEL_LO 0

// ----------------------------------------------------------------
// shared status and reference config field positions
// ----------------------------------------------------------------
`define ST_IDLE_STOP 15
`define ST_FLAG_LO   8
`define ST_RES_LO    0
`define REF_BG_HI    9
`define REF_BG_LO    8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CTRL   16'h0000
`define RST_WORD   32'h0000_0000

`endif

// [comparator_pkg.sv]
// types shared by the comparator control block and its channel slices
// assumes nothing beyond a systemverilog compiler
package comparator_pkg;

  // ----------------------------------------------------------------
  // software configuration of one channel
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       on;
    logic       oe;
    logic       inv;
    logic [1:0] edge_sel;
    logic       pref;
    logic [1:0] nsel;
  } chan_cfg_t;

  // ----------------------------------------------------------------
  // controls toward one analog comparator core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic       pos_ref;
    logic [1:0] neg_sel;
  } analog_ctrl_t;

  // ----------------------------------------------------------------
  // ahb-lite request signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
  } ahb_req_t;

  // ----------------------------------------------------------------
  // event edge selections
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_ANY  = 2'b11
  } edge_sel_t;

  // ----------------------------------------------------------------
  // per-channel state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic result;
    logic first_any;
    logic flag;
    logic fire;
  } chan_state_t;

  // ----------------------------------------------------------------
  // block state
  // ----------------------------------------------------------------
  typedef struct packed {
    chan_cfg_t [2:0] cfg;
    logic            idle_stop;
    logic [1:0]      bg_sel;
    logic [2:0]      irq_status;
    logic [2:0]      irq_mask;
    logic            irq;
    logic [2:0]      analog_en;
    logic            wr_pend;
    logic [7:0]      addr;
    logic [31:0]     rdata;
    logic            ready;
  } top_state_t;

endpackage

// [triple_comparator_control_bench.sv]
// self-checking bench of the comparator control block
// assumes zero-wait ahb-lite slave and the analog model on the far side
`timescale 1ns/1ps
module triple_comparator_control_bench;
  import comparator_pkg::*;
  // ----------------------------------------------------------------
  // signals, tables and tasks
  // ----------------------------------------------------------------
  logic                         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic                         idle_mode = 0;
  logic [31:0]                  haddr = 0, hwdata = 0, hrdata, rdv;
  logic [1:0]                   htrans = 0, bgsel;
  logic [2:0]                   hsize = 3'h2, raw, rpin, rpin_oe;
  logic                         hreadyout, hresp, irq;
  analog_ctrl_t [2:0]           actl;
  logic [7:0]                   pin_a = 8'h40, pin_b = 8'h20, pin_c = 8'h50;
  logic [7:0]                   pin_d = 8'h30, vref_pin = 8'h90;
  logic [15:0]                  ctl;
  int                           failures = 0, checks_done = 0;
  logic [7:0]  t_a [7] = '{8'h04, 8'h08, 8'h10, 8'h18, 8'h1c, 8'h0c, 8'h14};
  logic [31:0] t_d [7] = '{32'hffff_7fff, 32'h1c2c, '1, '1, '1, 32'hffff, '1};
  logic [31:0] t_e [7] = '{32'h62d3, 32'h0, 32'h300, 32'h7, 32'h0, 32'h8200, 32'h0};
  logic [15:0] s_c [6] = '{16'h8000, 16'h8001, 16'h8002, 16'h8003, 16'h8013, 16'h8013};
  logic [1:0]  s_b [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
  logic [5:0]  s_r = 6'b010101;

  always #50 hclk = ~hclk;

  comparator_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .raw_compare(raw), .idle_mode(idle_mode), .analog_ctrl(actl),
    .bandgap_source_select(bgsel), .result_pin(rpin), .result_pin_oe(rpin_oe), .irq(irq));
  comparator_analog_model cores (.analog_ctrl(actl), .bandgap_source_select(bgsel),
    .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d), .vref_pin(vref_pin),
    .raw_compare(raw));

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    if (n >= 50) begin
      failures++;
      test_done();
    end
  endtask

  // one single word transfer; read data left in rdv
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rdv = hrdata;
  endtask

  // move the input, look for the event, then clear flag and status
  task automatic step(input logic hi, input logic fire);
    pin_a <= hi ? 8'h40 : 8'h10;
    repeat (6) @(posedge hclk);
    bus(8'h14, 0, 0);
    chk("irq status", rdv, {31'h0, fire});
    chk("irq line", {31'h0, irq}, {31'h0, fire});
    bus(8'h00, 0, 0);
    chk("event flag", {31'h0, rdv[9]}, {31'h0, fire});
    bus(8'h00, 1, {16'h0, ctl});
    bus(8'h14, 1, 32'h7);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      bus(8'(i * 4), 0, 0);
      chk("reset value", rdv, 32'h0);
    end
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      bus(t_a[i], 1, t_d[i]);
      bus(t_a[i], 0, 0);
      chk("register row", rdv, t_e[i]);
    end
    for (int i = 0; i < 7; i++) bus(t_a[i], 1, 32'h0);
    $display("register table done");
    for (int i = 0; i < 6; i++) begin
      bus(8'h10, 1, {22'h0, s_b[i], 8'h0});
      bus(8'h00, 1, {16'h0, s_c[i]});
      repeat (6) @(posedge hclk);
      bus(8'h00, 0, 0);
      chk("result", {31'h0, rdv[8]}, {31'h0, s_r[i]});
      chk("analog ctrl", {28'h0, actl[0]}, {28'h0, 1'b1, s_c[i][4], s_c[i][1:0]});
      chk("bandgap", {30'h0, bgsel}, {30'h0, s_b[i]});
    end
    $display("input select done");
    bus(8'h0c, 1, 32'h8000);
    idle_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("idle stop", {31'h0, actl[0].enable}, 32'h0);
    idle_mode <= 1'b0;
    bus(8'h0c, 1, 32'h0);
    idle_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("idle run", {31'h0, actl[0].enable}, 32'h1);
    idle_mode <= 1'b0;
    $display("idle test done");
    bus(8'h00, 1, 32'hc000);
    repeat (6) @(posedge hclk);
    chk("pin out", {30'h0, rpin_oe[0], rpin[0]}, 32'h3);
    bus(8'h00, 1, 32'he000);
    repeat (6) @(posedge hclk);
    bus(8'h00, 0, 0);
    chk("inverted", rdv, 32'he000);
    chk("pin inverted", {31'h0, rpin[0]}, 32'h0);
    $display("invert test done");
    bus(8'h18, 1, 32'h7);
    for (int e = 1; e < 4; e++) begin
      ctl = {8'hc0, 2'(e), 6'h0};
      bus(8'h00, 1, 32'hc000);
      pin_a <= 8'h40;
      repeat (6) @(posedge hclk);
      bus(8'h00, 1, {16'h0, ctl});
      step(1'b0, 1'b1);
      step(1'b1, ctl[6]);
      step(1'b0, ctl[7]);
    end
    $display("edge test done");
    pin_a <= 8'h40;
    repeat (6) @(posedge hclk);
    bus(8'h14, 1, 32'h7);
    pin_a <= 8'h10;
    repeat (6) @(posedge hclk);
    bus(8'h14, 0, 0);
    chk("no retrigger", rdv, 32'h0);
    bus(8'h00, 1, {16'h0, ctl});
    bus(8'h18, 1, 32'h0);
    pin_a <= 8'h40;
    repeat (6) @(posedge hclk);
    bus(8'h14, 0, 0);
    chk("masked status", rdv, 32'h1);
    chk("masked irq", {31'h0, irq}, 32'h0);
    bus(8'h18, 1, 32'h1);
    repeat (2) @(posedge hclk);
    chk("unmasked irq", {31'h0, irq}, 32'h1);
    bus(8'h14, 1, 32'h1);
    repeat (2) @(posedge hclk);
    chk("cleared irq", {31'h0, irq}, 32'h0);
    $display("interrupt test done");
    bus(8'h00, 1, 32'h0);
    repeat (3) @(posedge hclk);
    chk("channel off", {27'h0, rpin_oe[0], actl[0]}, 32'h0);
    $display("disable test done");
    bus(8'h00, 1, 32'hc000);
    bus(8'h0c, 1, 32'h8000);
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("reset pins", {29'h0, rpin_oe[0], rpin[0], irq}, 32'h0);
    chk("reset analog", {20'h0, actl}, 32'h0);
    bus(8'h00, 0, 0);
    chk("reset ctrl", rdv, 32'h0);
    bus(8'h0c, 0, 0);
    chk("reset status", rdv, 32'h0);
    chk("okay response", {31'h0, hresp}, 32'h0);
    $display("mid reset test done");
    test_done();
  end
endmodule
